// ---- core/tlic_consts.svh ----
// constants for the two level interrupt controller
`ifndef TLIC_CONSTS_SVH
`define TLIC_CONSTS_SVH
`define TLIC_NSRC      15
`define TLIC_IDXW      4
`define TLIC_AW        3
`define TLIC_OFF_PEN   3'h0
`define TLIC_OFF_XEN   3'h1
`define TLIC_OFF_PPRI  3'h2
`define TLIC_OFF_XPRI  3'h3
`define TLIC_OFF_PND0  3'h4
`define TLIC_OFF_PND1  3'h5
`define TLIC_OFF_STAT  3'h6
`define TLIC_GEN_BIT   7
`define TLIC_NPRIM     7
`define TLIC_RST_BYTE  8'h00
`define TLIC_RST_PRIM  7'h00
`define TLIC_RST_PND   15'h0000
`define TLIC_AUTOCLR   15'h000f
`define TLIC_VEC_BASE  16'h0003
`define TLIC_VEC_SHIFT 3
`endif

// ---- core/tlic_pkg.sv ----
// types shared by the interrupt controller modules
package tlic_pkg;
    typedef struct packed {
        logic       valid;
        logic [3:0] idx;
    } tlic_pick_t;

    typedef struct packed {
        logic       high;
        logic [3:0] idx;
    } tlic_sel_t;

    typedef enum logic {
        TLIC_IDLE,
        TLIC_REQ
    } tlic_state_t;
endpackage : tlic_pkg

// ---- core/tlic_arbiter.sv ----
// fixed order arbiter: lowest source index wins
`timescale 1ns/1ps
`include "tlic_consts.svh"
module tlic_arbiter (
    // candidates
    input  wire logic [`TLIC_NSRC-1:0] req,
    // result
    output tlic_pkg::tlic_pick_t       pick
);
    logic [`TLIC_NSRC:0]   below;
    logic [`TLIC_NSRC-1:0] win;
    logic [`TLIC_IDXW-1:0] part [0:`TLIC_NSRC];

    assign below[0] = 1'b0;
    assign part[0]  = 4'h0;
    genvar i;
    generate
        for (i = 0; i < `TLIC_NSRC; i++) begin : g_src
            assign below[i+1] = below[i] | req[i];
            assign win[i]     = req[i] & ~below[i]; // see (RULE17) see (RULE20)
            assign part[i+1]  = part[i] | (win[i] ? 4'(i) : 4'h0);
        end
    endgenerate

    assign pick.valid = below[`TLIC_NSRC];
    assign pick.idx   = part[`TLIC_NSRC];
endmodule : tlic_arbiter

// ---- core/tlic_core.sv ----
// two level interrupt controller: flags, enables, priority, nesting
// Contract
// (RULE1) many sources, each on one of two levels
// (RULE2) valid condition sets source pending flag
// (RULE3) enabled pending flag raises request to core
// (RULE4) return instruction ends the service routine
// (RULE5) disabled source flag ignored, no vectoring
// (RULE6) flag sets whether enabled or not
// (RULE7) per source enable bit in two registers
// (RULE8) source enables count only with global enable
// (RULE9) global enable zero blocks every source
// (RULE10) some flags auto clear on vectoring
// (RULE11) flag left set re-requests after one instruction
// (RULE12) software writing one acts as real event
// (RULE13) per source priority bit, reset low
// (RULE14) high request preempts low routine
// (RULE15) high routine is never preempted
// (RULE16) higher level wins simultaneous requests
// (RULE17) fixed source order breaks level ties
// (RULE18) decode every cycle, request in one cycle
// (RULE19) equal or higher routine delays new request
// (RULE20) lower index wins, reset above all
`timescale 1ns/1ps
`include "tlic_consts.svh"
module tlic_core (
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  reset_n,
    // register port
    input  wire logic [`TLIC_AW-1:0]   reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [7:0]            reg_rdata,
    // peripheral condition pulses
    input  wire logic [`TLIC_NSRC-1:0] src_event,
    // cpu core side
    input  wire logic                  cpu_insn_done,
    input  wire logic                  cpu_vec_take,
    input  wire logic                  cpu_return_from_interrupt,
    output logic                       cpu_irq_req,
    output logic                       cpu_irq_high,
    output logic      [15:0]           cpu_vector
);
    // configuration registers
    logic [7:0]               pen_ff;
    logic [7:0]               nxt_pen;
    logic [7:0]               xen_ff;
    logic [7:0]               nxt_xen;
    logic [`TLIC_NPRIM-1:0]   ppri_ff;
    logic [`TLIC_NPRIM-1:0]   nxt_ppri;
    logic [7:0]               xpri_ff;
    logic [7:0]               nxt_xpri;
    // pending flags
    logic [`TLIC_NSRC-1:0]    pend_ff;
    logic [`TLIC_NSRC-1:0]    nxt_pend;
    // nesting and request state
    logic                     act_lo_ff;
    logic                     nxt_act_lo;
    logic                     act_hi_ff;
    logic                     nxt_act_hi;
    logic                     block_ff;
    logic                     nxt_block;
    tlic_pkg::tlic_state_t    st_ff;
    tlic_pkg::tlic_state_t    nxt_st;
    tlic_pkg::tlic_sel_t      sel_ff;
    tlic_pkg::tlic_sel_t      nxt_sel;
    logic [15:0]              vec_ff;
    logic [15:0]              nxt_vec;
    // read port
    logic [7:0]               rdata_ff;
    logic [7:0]               nxt_rdata;
    // decode
    logic [`TLIC_NSRC-1:0]    en_vec;
    logic [`TLIC_NSRC-1:0]    pri_vec;
    logic [`TLIC_NSRC-1:0]    cand;
    tlic_pkg::tlic_pick_t     hi_pick;
    tlic_pkg::tlic_pick_t     lo_pick;
    logic                     take_hi;
    logic                     take_lo;
    logic                     ack;
    logic [`TLIC_NSRC-1:0]    sw_set;
    logic [`TLIC_NSRC-1:0]    sw_clr;
    logic [`TLIC_NSRC-1:0]    auto_clr;
    logic [`TLIC_NSRC-1:0]    take_mask;

    assign en_vec  = {xen_ff, pen_ff[`TLIC_NPRIM-1:0]}; // see (RULE7)
    assign pri_vec = {xpri_ff, ppri_ff};                // see (RULE1) see (RULE13)

    // global gate overrides every source enable
    assign cand = pend_ff & en_vec & {`TLIC_NSRC{pen_ff[`TLIC_GEN_BIT]}}; // see (RULE5) see (RULE8) see (RULE9)

    tlic_arbiter u_arb_hi (
        .req  (cand & pri_vec),
        .pick (hi_pick)
    );

    tlic_arbiter u_arb_lo (
        .req  (cand & ~pri_vec),
        .pick (lo_pick)
    );

    // high level first; high routine blocks all, low routine blocks low
    assign take_hi = hi_pick.valid & ~act_hi_ff & ~block_ff; // see (RULE14) see (RULE15) see (RULE16)
    assign take_lo = ~take_hi & lo_pick.valid & ~act_hi_ff & ~act_lo_ff & ~block_ff; // see (RULE19)

    // vector call only counts while a request is offered
    assign ack = cpu_vec_take & (st_ff == tlic_pkg::TLIC_REQ);

    // register writes to the pending flags
    always_comb begin
        sw_set = '0;
        sw_clr = '0;
        if (reg_wr && reg_addr == `TLIC_OFF_PND0) begin
            sw_set[7:0] = reg_wdata;  // see (RULE12)
            sw_clr[7:0] = ~reg_wdata;
        end
        if (reg_wr && reg_addr == `TLIC_OFF_PND1) begin
            sw_set[`TLIC_NSRC-1:8] = reg_wdata[`TLIC_NSRC-9:0];
            sw_clr[`TLIC_NSRC-1:8] = ~reg_wdata[`TLIC_NSRC-9:0];
        end
    end

    assign take_mask = `TLIC_NSRC'(1) << sel_ff.idx;
    assign auto_clr  = ack ? (take_mask & `TLIC_AUTOCLR) : '0; // see (RULE10)

    // set wins over any clear in the same cycle
    assign nxt_pend = (pend_ff & ~sw_clr & ~auto_clr) | sw_set | src_event; // see (RULE2) see (RULE6)

    // configuration writes
    always_comb begin
        nxt_pen  = pen_ff;
        nxt_xen  = xen_ff;
        nxt_ppri = ppri_ff;
        nxt_xpri = xpri_ff;
        if (reg_wr) begin
            case (reg_addr)
                `TLIC_OFF_PEN:  nxt_pen  = reg_wdata;
                `TLIC_OFF_XEN:  nxt_xen  = reg_wdata;
                `TLIC_OFF_PPRI: nxt_ppri = reg_wdata[`TLIC_NPRIM-1:0];
                `TLIC_OFF_XPRI: nxt_xpri = reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // nesting levels and post return hold
    always_comb begin
        nxt_act_lo = act_lo_ff;
        nxt_act_hi = act_hi_ff;
        nxt_block  = block_ff;
        if (cpu_return_from_interrupt) begin
            // the innermost routine is always the high one if both run
            if (act_hi_ff) begin
                nxt_act_hi = 1'b0; // see (RULE4)
            end else begin
                nxt_act_lo = 1'b0;
            end
        end
        if (ack) begin
            if (sel_ff.high) begin
                nxt_act_hi = 1'b1;
            end else begin
                nxt_act_lo = 1'b1;
            end
        end
        // one instruction must finish after a return before the next call
        if (cpu_return_from_interrupt) begin
            nxt_block = 1'b1; // see (RULE11) see (RULE19)
        end else if (cpu_insn_done) begin
            nxt_block = 1'b0;
        end
    end

    // request offer, re-decoded every cycle until taken
    always_comb begin
        nxt_st  = st_ff;
        nxt_sel = sel_ff;
        nxt_vec = vec_ff;
        case (st_ff)
            tlic_pkg::TLIC_IDLE,
            tlic_pkg::TLIC_REQ: begin
                if (ack || cpu_return_from_interrupt || !(take_hi || take_lo)) begin
                    // retract; a stale vector must never be called
                    nxt_st = tlic_pkg::TLIC_IDLE;
                end else begin
                    nxt_st = tlic_pkg::TLIC_REQ; // see (RULE3) see (RULE18)
                    nxt_sel.high = take_hi;
                    nxt_sel.idx  = take_hi ? hi_pick.idx : lo_pick.idx;
                    nxt_vec = `TLIC_VEC_BASE + (16'(nxt_sel.idx) << `TLIC_VEC_SHIFT);
                end
            end
            default: begin
                nxt_st = tlic_pkg::TLIC_IDLE;
            end
        endcase
    end

    // read data, one cycle after the strobe and only then
    always_comb begin
        nxt_rdata = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                `TLIC_OFF_PEN:  nxt_rdata = pen_ff;
                `TLIC_OFF_XEN:  nxt_rdata = xen_ff;
                `TLIC_OFF_PPRI: nxt_rdata = {1'b0, ppri_ff};
                `TLIC_OFF_XPRI: nxt_rdata = xpri_ff;
                `TLIC_OFF_PND0: nxt_rdata = pend_ff[7:0];
                `TLIC_OFF_PND1: nxt_rdata = {1'b0, pend_ff[`TLIC_NSRC-1:8]};
                `TLIC_OFF_STAT: nxt_rdata = {act_hi_ff, act_lo_ff, block_ff,
                                             (st_ff == tlic_pkg::TLIC_REQ), sel_ff.idx};
                default:        nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pen_ff    <= `TLIC_RST_BYTE;
            xen_ff    <= `TLIC_RST_BYTE;
            ppri_ff   <= `TLIC_RST_PRIM; // see (RULE13)
            xpri_ff   <= `TLIC_RST_BYTE;
            pend_ff   <= `TLIC_RST_PND;
            act_lo_ff <= 1'b0;
            act_hi_ff <= 1'b0;
            block_ff  <= 1'b0;
            st_ff     <= tlic_pkg::TLIC_IDLE;
            sel_ff    <= '0;
            vec_ff    <= `TLIC_VEC_BASE;
            rdata_ff  <= 8'h00;
        end else begin
            pen_ff    <= nxt_pen;
            xen_ff    <= nxt_xen;
            ppri_ff   <= nxt_ppri;
            xpri_ff   <= nxt_xpri;
            pend_ff   <= nxt_pend;
            act_lo_ff <= nxt_act_lo;
            act_hi_ff <= nxt_act_hi;
            block_ff  <= nxt_block;
            st_ff     <= nxt_st;
            sel_ff    <= nxt_sel;
            vec_ff    <= nxt_vec;
            rdata_ff  <= nxt_rdata;
        end
    end

    assign reg_rdata    = rdata_ff;
    assign cpu_irq_req  = (st_ff == tlic_pkg::TLIC_REQ);
    assign cpu_irq_high = sel_ff.high;
    assign cpu_vector   = vec_ff;
endmodule : tlic_core

// ---- sim/tlic_core_props.sv ----
// port checker for the interrupt controller
`timescale 1ns/1ps
module tlic_core_props (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        reset_n,
    // register port
    input wire logic [2:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    // cpu side
    input wire logic        cpu_insn_done,
    input wire logic        cpu_vec_take,
    input wire logic        cpu_return_from_interrupt,
    input wire logic        cpu_irq_req,
    input wire logic        cpu_irq_high,
    input wire logic [15:0] cpu_vector
);
    logic gen_ff, hi_ff, lo_ff, nxt_gen, nxt_hi, nxt_lo, en_wr;
    assign en_wr = reg_wr && reg_addr == 3'h0;
    always_comb begin
        nxt_gen = en_wr ? reg_wdata[7] : gen_ff;
        nxt_hi  = hi_ff;
        nxt_lo  = lo_ff;
        if (cpu_vec_take && cpu_irq_req) begin
            nxt_hi = hi_ff | cpu_irq_high;
            nxt_lo = lo_ff | !cpu_irq_high;
        end else if (cpu_return_from_interrupt) begin
            nxt_hi = 1'b0;
            // return closes the high routine first
            nxt_lo = lo_ff & hi_ff;
        end
    end
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            gen_ff <= 1'b0;
            hi_ff  <= 1'b0;
            lo_ff  <= 1'b0;
        end else begin
            gen_ff <= nxt_gen;
            hi_ff  <= nxt_hi;
            lo_ff  <= nxt_lo;
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    AST_GLOBAL_OFF: assert property (!gen_ff && !en_wr |=> !cpu_irq_req)
        else $error("request while globally off");
    AST_ROSE_GLOBAL: assert property ($rose(cpu_irq_req) |-> $past(gen_ff))
        else $error("request rose without global enable");
    AST_VECTOR_MAP: assert property (cpu_irq_req |-> cpu_vector[2:0] == 3'h3 && cpu_vector[15:7] == 9'h000)
        else $error("vector off the table");
    AST_TAKE_DROP: assert property (cpu_vec_take && cpu_irq_req |=> !cpu_irq_req)
        else $error("request stayed after call");
    AST_RETURN_FROM_INTERRUPT_DROP: assert property (cpu_return_from_interrupt |=> !cpu_irq_req)
        else $error("request right after return");
    AST_ONE_INSN: assert property (cpu_return_from_interrupt ##1 !cpu_insn_done |=> !cpu_irq_req)
        else $error("request before one instruction");
    AST_HI_NO_PREEMPT: assert property (hi_ff |-> !cpu_irq_req)
        else $error("high routine preempted");
    AST_LO_ONLY_HIGH: assert property (lo_ff && cpu_irq_req |-> cpu_irq_high)
        else $error("low request inside low routine");
endmodule : tlic_core_props
bind tlic_core tlic_core_props u_props (
    .sys_clk       (sys_clk),
    .reset_n       (reset_n),
    .reg_addr      (reg_addr),
    .reg_wdata     (reg_wdata),
    .reg_wr        (reg_wr),
    .cpu_insn_done (cpu_insn_done),
    .cpu_vec_take  (cpu_vec_take),
    .cpu_return_from_interrupt      (cpu_return_from_interrupt),
    .cpu_irq_req   (cpu_irq_req),
    .cpu_irq_high  (cpu_irq_high),
    .cpu_vector    (cpu_vector)
);

// ---- sim/tlic_cpu_model.sv ----
// behavioural cpu core facing the interrupt controller
`timescale 1ns/1ps
module tlic_cpu_model (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic reset_n,
    // bench control
    input  wire logic take_en,
    input  wire logic ret_go,
    // controller side
    input  wire logic irq_req,
    output logic      insn_done,
    output logic      vec_take,
    output logic      return_from_interrupt
);
    logic ph_ff;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ph_ff     <= 1'b0;
            insn_done <= 1'b0;
            vec_take  <= 1'b0;
            return_from_interrupt      <= 1'b0;
        end else begin
            ph_ff     <= !ph_ff;
            return_from_interrupt      <= ret_go;
            // no boundary in the return cycle itself
            insn_done <= ph_ff && !ret_go;
            vec_take  <= ph_ff && take_en && irq_req && !vec_take;
        end
    end
endmodule : tlic_cpu_model

// ---- sim/testbench.sv ----
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
module testbench;
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [2:0]  reg_addr = 3'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [14:0] src_event = 15'h0000;
    logic        take_en = 1'b0;
    logic        ret_go = 1'b0;
    logic [7:0]  reg_rdata;
    logic [15:0] vector;
    logic        insn_done, vec_take, return_from_interrupt, irq_req, irq_high;
    int          n_errors = 0;
    int          checked = 0;
    int          cycles = 0;
    always #12.5 sys_clk = ~sys_clk;
    tlic_core DUT (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_event(src_event),
        .cpu_insn_done(insn_done), .cpu_vec_take(vec_take), .cpu_return_from_interrupt(return_from_interrupt), .cpu_irq_req(irq_req),
        .cpu_irq_high(irq_high), .cpu_vector(vector));
    tlic_cpu_model u_cpu (.sys_clk(sys_clk), .reset_n(reset_n), .take_en(take_en), .ret_go(ret_go),
        .irq_req(irq_req), .insn_done(insn_done), .vec_take(vec_take), .return_from_interrupt(return_from_interrupt));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        check({8'h00, reg_rdata}, {8'h00, exp});
    endtask : rd
    task automatic ev(input int i);
        @(posedge sys_clk);
        src_event <= 15'h0001 << i;
        @(posedge sys_clk);
        src_event <= 15'h0000;
    endtask : ev
    task automatic ret;
        @(posedge sys_clk);
        ret_go <= 1'b1;
        @(posedge sys_clk);
        ret_go <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask : ret
    task automatic set_take(input logic b);
        @(posedge sys_clk);
        take_en <= b;
    endtask : set_take
    task automatic wait_req(input logic [15:0] v, input logic h);
        int i;
        i = 0;
        do begin
            @(negedge sys_clk);
            i++;
        end while (irq_req !== 1'b1 && i < 20);
        check({irq_req, irq_high, vector[13:0]}, {1'b1, h, v[13:0]});
    endtask : wait_req
    task automatic no_req(input int n);
        repeat (n) begin
            @(negedge sys_clk);
            check({15'h0000, irq_req}, 16'h0000);
        end
    endtask : no_req
    task automatic t_regs;
        for (int a = 0; a < 8; a++)
            rd(a[2:0], 8'h00);
        wr(3'h2, 8'h7f);
        rd(3'h2, 8'h7f);
        wr(3'h2, 8'h00);
        wr(3'h7, 8'hff);
        rd(3'h7, 8'h00);
    endtask : t_regs
    task automatic t_basic;
        set_take(1'b1);
        wr(3'h0, 8'h82);
        ev(1);
        // flag lands at the event edge, request one edge later
        no_req(1);
        @(negedge sys_clk);
        check({15'h0000, irq_req}, 16'h0001);
        wait_req(16'h000b, 1'b0);
        repeat (4) @(posedge sys_clk);
        rd(3'h4, 8'h00);
        ret();
    endtask : t_basic
    task automatic t_mask;
        set_take(1'b0);
        wr(3'h0, 8'h80);
        ev(4);
        no_req(6);
        rd(3'h4, 8'h10);
        wr(3'h0, 8'h10);
        no_req(6);
        wr(3'h0, 8'h90);
        wait_req(16'h0023, 1'b0);
        set_take(1'b1);
        repeat (6) @(posedge sys_clk);
        set_take(1'b0);
        rd(3'h4, 8'h10);
        ret();
        wait_req(16'h0023, 1'b0);
        wr(3'h4, 8'h00);
        // the offer latched at the clearing edge stands one more cycle
        @(posedge sys_clk);
        no_req(4);
    endtask : t_mask
    task automatic t_order;
        wr(3'h0, 8'hb0);
        wr(3'h4, 8'h30);
        wait_req(16'h0023, 1'b0);
        wr(3'h2, 8'h20);
        repeat (3) @(posedge sys_clk);
        wait_req(16'h002b, 1'b1);
        wr(3'h2, 8'h00);
        set_take(1'b1);
        repeat (6) @(posedge sys_clk);
        set_take(1'b0);
        no_req(6);
        wr(3'h2, 8'h20);
        wait_req(16'h002b, 1'b1);
        set_take(1'b1);
        repeat (6) @(posedge sys_clk);
        set_take(1'b0);
        wr(3'h2, 8'h30);
        no_req(6);
        ret();
        wait_req(16'h0023, 1'b1);
        wr(3'h4, 8'h00);
        ret();
        no_req(4);
    endtask : t_order
    task automatic final_report;
        if (n_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            final_report();
        end
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_regs();
        t_basic();
        t_mask();
        t_order();
        final_report();
    end
endmodule : testbench
